// *** byte_mask_capture.v ***
`timescale 1ns/1ns
module byte_mask_capture (
    input wire clk,
    input wire rst_n,
    input wire strobe_s,
    input wire mask_s,
    input wire [7:0] data_s,
    input wire write_win,
    output reg [7:0] byte_out,
    output reg byte_valid,
    output reg byte_masked
);
    reg strobe_d_r;
    wire edge_any;
    assign edge_any = strobe_s ^ strobe_d_r;
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            strobe_d_r <= 1'b0;
            byte_out <= 8'h00;
            byte_valid <= 1'b0;
            byte_masked <= 1'b0;
        end
        else
        begin
            strobe_d_r <= strobe_s;
            byte_valid <= 1'b0;
            byte_masked <= 1'b0;
            if (edge_any && write_win)
            begin
                if (mask_s)
                    byte_masked <= 1'b1;
                else
                begin
                    byte_valid <= 1'b1;
                    byte_out <= data_s;
                end
            end
        end
    end
endmodule // byte_mask_capture

// *** ctrl_model.sv ***
`timescale 1ns/1ns
module ctrl_model (
    input wire ref_clk,
    output reg ck_t,
    output reg ck_c,
    output reg en,
    output reg cs_n,
    output reg [2:0] cmd,
    output reg [2:0] ba,
    output reg [12:0] addr,
    output reg term,
    output reg strb,
    output reg msk,
    output reg [7:0] dat,
    output reg strb_u,
    output reg msk_u,
    output reg [7:0] dat_u,
    output reg rp_n
);
    initial
    begin
        {ck_t, en, term, strb, msk, dat, ba, addr} = 0;
        {strb_u, msk_u, dat_u} = 0;
        {ck_c, cs_n, rp_n, cmd} = 6'h3f;
    end
    task tick(input integer n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task set(input e, input t, input r);
        tick(1);
        en = e;
        term = t;
        rp_n = r;
    endtask
    task send(input c, input [2:0] k, input [2:0] b, input [12:0] a);
        tick(1);
        cs_n = c;
        cmd = k;
        ba = b;
        addr = a;
        tick(8);
        ck_t = 1;
        ck_c = 0;
        tick(8);
        ck_t = 0;
        ck_c = 1;
        tick(4);
        {cs_n, cmd, ba, addr} = {1'b1, ~k, ~b, ~a};
        tick(4);
    endtask
    task burst(input [3:0] m, input [31:0] d);
        integer i;
        for (i = 0; i < 4; i = i + 1)
        begin
            msk = m[i];
            dat = d[8*i +: 8];
            msk_u = ~m[i];
            dat_u = ~d[8*i +: 8];
            tick(4);
            strb = ~strb;
            strb_u = ~strb_u;
            tick(4);
        end
        dat = ~dat;
        dat_u = ~dat_u;
    endtask
endmodule // ctrl_model

// *** pin_sync.v ***
`timescale 1ns/1ns
module pin_sync #(
    parameter W = 1
) (
    input wire clk,
    input wire rst_n,
    input wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] s1_r;
    reg [W-1:0] s2_r;
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_r <= {W{1'b0}};
            s2_r <= {W{1'b0}};
        end
        else
        begin
            s1_r <= d;
            s2_r <= s1_r;
        end
    end
    assign q = s2_r;
endmodule // pin_sync

// *** sdram_command_pin_interface.v ***
`timescale 1ns/1ns
`include "sdram_pin_defs.vh"
// Functional notes
// - Command, bank and address inputs are captured on the rising edge of the true clock.
// - Clock enable low enters power-down, or self-refresh on a refresh command with all banks idle.
// - Clock enable high exits self-refresh without a clock edge.
// - In self-refresh only clock enable and reset are listened to.
// - A command with chip select high is ignored.
// - Commands decode from chip select and the three strobes.
// - Captured termination high enables termination on data pins.
// - Termination is ignored when disabled in mode registers or in self-refresh.
// - A byte with its mask high during a write is discarded.
// - Masks are sampled on both data strobe edges.
// - Self-refresh mode bit A6 selects automatic mode; A7 selects extended temperature in manual mode.
// - Bank inputs pick the bank, or the mode register on a set command.
// - The auto-precharge bit means auto-precharge or all-bank precharge.
// - The burst-chop bit high is a full burst and low a chopped one.
// - Reset low holds the device in reset after a two-stage ref_clk synchronizer.
module sdram_command_pin_interface (
    input wire ref_clk,
    input wire rst_n,
    input wire clock_true,
    input wire clock_complement,
    input wire clock_enable_in,
    input wire chip_select_n,
    input wire row_strobe_n,
    input wire column_strobe_n,
    input wire write_enable_n,
    input wire termination_ctrl,
    input wire [2:0] bank_select_inputs,
    input wire [12:0] address_in,
    input wire lower_data_strobe,
    input wire upper_data_strobe,
    input wire lower_byte_mask,
    input wire upper_byte_mask,
    input wire [7:0] lower_data_in,
    input wire [7:0] upper_data_in,
    input wire reset_in_n,
    output reg [2:0] cmd_code,
    output reg cmd_valid,
    output reg [2:0] cmd_bank,
    output reg [12:0] cmd_addr,
    output reg auto_precharge,
    output reg precharge_all,
    output reg burst_chop,
    output reg [1:0] power_state,
    output reg buffers_on,
    output reg termination_on,
    output reg auto_self_refresh,
    output reg ext_temp_self_refresh,
    output reg [7:0] lower_byte_out,
    output reg lower_byte_valid,
    output reg [7:0] upper_byte_out,
    output reg upper_byte_valid
);
    reg rst_s1_r;
    reg rst_s2_r;
    wire rst_core_n;
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end
        else
        begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end
    wire [0:0] pin_rst_s;
    pin_sync #(.W(1)) u_rst_sync (
        .clk(ref_clk),
        .rst_n(rst_s2_r),
        .d(reset_in_n),
        .q(pin_rst_s)
    );
    assign rst_core_n = rst_s2_r & pin_rst_s[0];

    wire [35:0] pins_s;
    pin_sync #(.W(36)) u_pin_sync (
        .clk(ref_clk),
        .rst_n(rst_s2_r),
        .d({clock_true, clock_complement, clock_enable_in, chip_select_n,
            row_strobe_n, column_strobe_n, write_enable_n, termination_ctrl,
            bank_select_inputs, address_in, lower_data_strobe,
            upper_data_strobe, lower_byte_mask, upper_byte_mask,
            lower_data_in[7:0]}),
        .q(pins_s)
    );
    wire [7:0] upper_s;
    pin_sync #(.W(8)) u_upd_sync (
        .clk(ref_clk),
        .rst_n(rst_s2_r),
        .d(upper_data_in),
        .q(upper_s)
    );
    wire ck_s = pins_s[35];
    wire ckb_s = pins_s[34];
    wire cke_s = pins_s[33];
    wire cs_s = pins_s[32];
    wire [2:0] rcw_s = pins_s[31:29];
    wire odt_s = pins_s[28];
    wire [2:0] ba_s = pins_s[27:25];
    wire [12:0] a_s = pins_s[24:12];
    wire ldqs_s = pins_s[11];
    wire udqs_s = pins_s[10];
    wire ldm_s = pins_s[9];
    wire udm_s = pins_s[8];
    wire [7:0] ldq_s = pins_s[7:0];

    reg ck_d_r;
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [7:0] bank_open_r;
    reg term_dis_a_r;
    reg term_dis_b_r;
    reg writing_r;
    wire ck_rise = ck_s & ~ck_d_r & ~ckb_s;
    wire in_sref = (state_r == `ST_SREF);
    wire cmd_buf_en = ~in_sref & (state_r != `ST_PDOWN);
    wire take = ck_rise & cmd_buf_en & cke_s & ~cs_s;
    wire [2:0] cmd = rcw_s;

    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            `ST_IDLE:
                if (ck_rise && !cke_s)
                    state_nxt = (!cs_s && cmd == `CMD_REF) ? `ST_SREF :
                                `ST_PDOWN;
                else if (bank_open_r != 8'h00)
                    state_nxt = `ST_ACTIVE;
            `ST_ACTIVE:
                if (ck_rise && !cke_s)
                    state_nxt = `ST_PDOWN;
                else if (bank_open_r == 8'h00)
                    state_nxt = `ST_IDLE;
            `ST_PDOWN:
                if (ck_rise && cke_s)
                    state_nxt = (bank_open_r != 8'h00) ? `ST_ACTIVE :
                                `ST_IDLE;
            `ST_SREF:
                if (cke_s)
                    state_nxt = `ST_IDLE;
            default:
                state_nxt = `ST_IDLE;
        endcase
    end

    always @(posedge ref_clk or negedge rst_core_n)
    begin
        if (!rst_core_n)
        begin
            ck_d_r <= 1'b0;
            state_r <= `ST_IDLE;
            bank_open_r <= 8'h00;
            term_dis_a_r <= 1'b1;
            term_dis_b_r <= 1'b1;
            writing_r <= 1'b0;
            cmd_code <= `CMD_NOP;
            cmd_valid <= 1'b0;
            cmd_bank <= 3'h0;
            cmd_addr <= 13'h0000;
            auto_precharge <= 1'b0;
            precharge_all <= 1'b0;
            burst_chop <= 1'b0;
            power_state <= `ST_IDLE;
            buffers_on <= 1'b1;
            termination_on <= 1'b0;
            auto_self_refresh <= 1'b0;
            ext_temp_self_refresh <= 1'b0;
        end
        else
        begin
            ck_d_r <= ck_s;
            state_r <= state_nxt;
            power_state <= state_nxt;
            buffers_on <= (state_nxt != `ST_SREF) &&
                          (state_nxt != `ST_PDOWN);
            cmd_valid <= take;
            termination_on <= odt_s & (state_nxt != `ST_SREF) &
                              ~(term_dis_a_r & term_dis_b_r);
            if (take)
            begin
                cmd_code <= cmd;
                cmd_bank <= ba_s;
                cmd_addr <= a_s;
                auto_precharge <= 1'b0;
                precharge_all <= 1'b0;
                case (cmd)
                    `CMD_ACT:
                        bank_open_r[ba_s] <= 1'b1;
                    `CMD_PRE:
                        if (a_s[`AP_BIT])
                        begin
                            bank_open_r <= 8'h00;
                            precharge_all <= 1'b1;
                        end
                        else
                            bank_open_r[ba_s] <= 1'b0;
                    `CMD_RD, `CMD_WR:
                    begin
                        auto_precharge <= a_s[`AP_BIT];
                        if (a_s[`AP_BIT])
                            bank_open_r[ba_s] <= 1'b0;
                        burst_chop <= ~a_s[`BC_BIT];
                        writing_r <= (cmd == `CMD_WR);
                    end
                    `CMD_MRS:
                    begin
                        if (ba_s == `MR_SEL_TERM_A)
                            term_dis_a_r <= (a_s[9] | a_s[6] | a_s[2])
                                            == 1'b0;
                        if (ba_s == `MR_SEL_SR)
                        begin
                            term_dis_b_r <= a_s[10:9] == 2'h0;
                            auto_self_refresh <= a_s[`SR_ASR_BIT];
                            ext_temp_self_refresh <= ~a_s[`SR_ASR_BIT] &
                                                     a_s[`SR_EXT_BIT];
                        end
                    end
                    default:
                        writing_r <= writing_r;
                endcase
            end
            else if (!cke_s)
                writing_r <= 1'b0;
        end
    end

    wire [7:0] lb;
    wire [7:0] ub;
    wire lv;
    wire uv;
    wire win = writing_r & cke_s;
    byte_mask_capture u_lower (
        .clk(ref_clk),
        .rst_n(rst_core_n),
        .strobe_s(ldqs_s),
        .mask_s(ldm_s),
        .data_s(ldq_s),
        .write_win(win),
        .byte_out(lb),
        .byte_valid(lv),
        .byte_masked()
    );
    byte_mask_capture u_upper (
        .clk(ref_clk),
        .rst_n(rst_core_n),
        .strobe_s(udqs_s),
        .mask_s(udm_s),
        .data_s(upper_s),
        .write_win(win),
        .byte_out(ub),
        .byte_valid(uv),
        .byte_masked()
    );
    always @(posedge ref_clk or negedge rst_core_n)
    begin
        if (!rst_core_n)
        begin
            lower_byte_out <= 8'h00;
            lower_byte_valid <= 1'b0;
            upper_byte_out <= 8'h00;
            upper_byte_valid <= 1'b0;
        end
        else
        begin
            lower_byte_out <= lb;
            lower_byte_valid <= lv;
            upper_byte_out <= ub;
            upper_byte_valid <= uv;
        end
    end
endmodule // sdram_command_pin_interface

// *** sdram_command_pin_interface_tb.sv ***
`timescale 1ns/1ns
`include "sdram_pin_defs.vh"
module sdram_command_pin_interface_tb;
    reg ref_clk = 0;
    reg rst_n = 0;
    wire ck_t, ck_c, en, cs_n, term, strb, msk, rp_n;
    wire [2:0] cmd, ba, code, bank;
    wire [12:0] addr, caddr;
    wire [7:0] dat, lo_out, up_out, dat_u;
    wire strb_u, msk_u;
    wire [1:0] ps;
    wire cv, ap, pa, bc, buf_on, term_on, automatic_self_refresh, ext, lo_v, up_v;
    integer n_mismatch = 0, tests_run = 0, n_cmd = 0, n_lo = 0, n_up = 0;
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        n_cmd <= n_cmd + (cv === 1'b1);
        n_lo <= n_lo + (lo_v === 1'b1);
        n_up <= n_up + (up_v === 1'b1);
    end
    ctrl_model u_ctrl_model (.ref_clk(ref_clk), .ck_t(ck_t), .ck_c(ck_c),
        .en(en), .cs_n(cs_n), .cmd(cmd), .ba(ba), .addr(addr), .term(term),
        .strb(strb), .msk(msk), .dat(dat), .strb_u(strb_u), .msk_u(msk_u),
        .dat_u(dat_u), .rp_n(rp_n));
    sdram_command_pin_interface u_sdram_command_pin_interface (
        .ref_clk(ref_clk), .rst_n(rst_n), .clock_true(ck_t),
        .clock_complement(ck_c), .clock_enable_in(en),
        .chip_select_n(cs_n), .row_strobe_n(cmd[2]),
        .column_strobe_n(cmd[1]), .write_enable_n(cmd[0]),
        .termination_ctrl(term), .bank_select_inputs(ba), .address_in(addr),
        .lower_data_strobe(strb), .upper_data_strobe(strb_u),
        .lower_byte_mask(msk), .upper_byte_mask(msk_u),
        .lower_data_in(dat), .upper_data_in(dat_u), .reset_in_n(rp_n),
        .cmd_code(code), .cmd_valid(cv), .cmd_bank(bank), .cmd_addr(caddr),
        .auto_precharge(ap), .precharge_all(pa), .burst_chop(bc),
        .power_state(ps), .buffers_on(buf_on), .termination_on(term_on),
        .auto_self_refresh(automatic_self_refresh), .ext_temp_self_refresh(ext),
        .lower_byte_out(lo_out), .lower_byte_valid(lo_v),
        .upper_byte_out(up_out), .upper_byte_valid(up_v));
    task chk(input [8*8-1:0] nm, input [12:0] e, input [12:0] g);
        tests_run = tests_run + 1;
        if (g !== e)
        begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH %0s exp %h got %h", nm, e, g);
        end
    endtask
    task do_cmd(input v, input c, input [2:0] k, input [2:0] b,
        input [12:0] a);
        integer n0;
        n0 = n_cmd;
        u_ctrl_model.send(c, k, b, a);
        chk("valid", v, n_cmd - n0);
        if (v)
        begin
            chk("code", k, code);
            chk("bank", b, bank);
            chk("addr", a, caddr);
        end
    endtask
    task finish_test;
        $display("mismatches %0d compares %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        #100000;
        n_mismatch = n_mismatch + 1;
        finish_test;
    end
    initial
    begin
        repeat (5) @(posedge ref_clk);
        #1 rst_n = 1;
        u_ctrl_model.tick(1);
        chk("code", 3'h7, code);
        chk("buf", 1, buf_on);
        u_ctrl_model.set(1, 0, 1);
        u_ctrl_model.tick(6);
        do_cmd(1, 0, `CMD_MRS, `MR_SEL_TERM_A, 13'h0004);
        do_cmd(1, 0, `CMD_MRS, `MR_SEL_SR, 13'h0040);
        chk("asr", 1, automatic_self_refresh);
        do_cmd(1, 0, `CMD_MRS, `MR_SEL_SR, 13'h0080);
        chk("asr_ext", 2'h1, {automatic_self_refresh, ext});
        do_cmd(1, 0, `CMD_ACT, 3'h5, 13'h1abc);
        chk("state", `ST_ACTIVE, ps);
        do_cmd(1, 0, `CMD_RD, 3'h5, 13'h0400);
        chk("ap_bc", 2'h3, {ap, bc});
        do_cmd(0, 1, `CMD_ACT, 3'h1, 13'h0000);
        do_cmd(1, 0, `CMD_WR, 3'h5, 13'h1000);
        chk("ap_bc", 2'h0, {ap, bc});
        u_ctrl_model.burst(4'h2, 32'h44332211);
        u_ctrl_model.tick(8);
        chk("lo_n", 3, n_lo);
        chk("up_n", 1, n_up);
        do_cmd(1, 0, `CMD_PRE, 3'h0, 13'h0400);
        chk("pall", 1, pa);
        do_cmd(1, 0, `CMD_ZQ, 3'h0, 13'h0000);
        do_cmd(1, 0, `CMD_REF, 3'h0, 13'h0000);
        u_ctrl_model.set(1, 1, 1);
        u_ctrl_model.tick(8);
        chk("term", 1, term_on);
        u_ctrl_model.set(0, 1, 1);
        u_ctrl_model.send(0, `CMD_REF, 3'h0, 13'h0000);
        chk("state", `ST_SREF, ps);
        chk("buf_term", 2'h0, {buf_on, term_on});
        do_cmd(0, 0, `CMD_ACT, 3'h2, 13'h0011);
        u_ctrl_model.set(1, 1, 1);
        u_ctrl_model.tick(8);
        chk("state", `ST_IDLE, ps);
        chk("term", 1, term_on);
        u_ctrl_model.set(0, 0, 1);
        u_ctrl_model.send(1, `CMD_NOP, 3'h0, 13'h0000);
        chk("state", `ST_PDOWN, ps);
        u_ctrl_model.set(1, 0, 1);
        u_ctrl_model.send(1, `CMD_NOP, 3'h0, 13'h0000);
        chk("state", `ST_IDLE, ps);
        do_cmd(1, 0, `CMD_ACT, 3'h3, 13'h0123);
        u_ctrl_model.set(1, 0, 0);
        u_ctrl_model.tick(8);
        chk("state", `ST_IDLE, ps);
        chk("code", 3'h7, code);
        u_ctrl_model.set(1, 0, 1);
        u_ctrl_model.tick(8);
        finish_test;
    end
endmodule // sdram_command_pin_interface_tb

// *** sdram_cpi_sva.sv ***
`timescale 1ns/1ns
`include "sdram_pin_defs.vh"
module sdram_cpi_sva (
    input wire ref_clk,
    input wire rst_n,
    input wire clock_enable_in,
    input wire chip_select_n,
    input wire row_strobe_n,
    input wire column_strobe_n,
    input wire write_enable_n,
    input wire [2:0] bank_select_inputs,
    input wire lower_byte_mask,
    input wire [7:0] lower_data_in,
    input wire reset_in_n,
    input wire [2:0] cmd_code,
    input wire cmd_valid,
    input wire [2:0] cmd_bank,
    input wire [12:0] cmd_addr,
    input wire auto_precharge,
    input wire precharge_all,
    input wire burst_chop,
    input wire [1:0] power_state,
    input wire buffers_on,
    input wire termination_on,
    input wire [7:0] lower_byte_out,
    input wire lower_byte_valid
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    wire rw = cmd_code == `CMD_RD || cmd_code == `CMD_WR;
    wire sref = power_state == `ST_SREF;
    property p_cs;
        cmd_valid |-> !$past(chip_select_n, 4);
    endproperty
    a_cs: assert property (p_cs) else $error("deselected taken");
    property p_code;
        cmd_valid |-> cmd_code == $past({row_strobe_n, column_strobe_n,
            write_enable_n}, 4) ##1 !cmd_valid;
    endproperty
    a_code: assert property (p_code) else $error("bad code");
    property p_bank;
        cmd_valid |-> cmd_bank == $past(bank_select_inputs, 4);
    endproperty
    a_bank: assert property (p_bank) else $error("bad bank");
    property p_ap;
        cmd_valid && (rw || cmd_code == `CMD_PRE) |->
            (rw ? auto_precharge : precharge_all) == cmd_addr[`AP_BIT];
    endproperty
    a_ap: assert property (p_ap) else $error("bad precharge");
    property p_bc;
        cmd_valid && rw |-> burst_chop == !cmd_addr[`BC_BIT];
    endproperty
    a_bc: assert property (p_bc) else $error("bad chop");
    property p_sref;
        sref |-> !buffers_on && !termination_on && !cmd_valid;
    endproperty
    a_sref: assert property (p_sref) else $error("sref leak");
    property p_exit;
        sref && clock_enable_in |-> ##[1:6] !sref;
    endproperty
    a_exit: assert property (p_exit) else $error("no exit");
    property p_mask;
        lower_byte_valid |-> !$past(lower_byte_mask, 4) &&
            lower_byte_out == $past(lower_data_in, 4);
    endproperty
    a_mask: assert property (p_mask) else $error("bad byte");
    property p_rst;
        !reset_in_n [*6] |-> power_state == `ST_IDLE && !cmd_valid;
    endproperty
    a_rst: assert property (p_rst) else $error("no reset");
    c_wr: cover property (cmd_valid && cmd_code == `CMD_WR);
    c_sref: cover property (sref);
    c_byte: cover property (lower_byte_valid);
endmodule // sdram_cpi_sva
bind sdram_command_pin_interface sdram_cpi_sva u_sdram_cpi_sva (.*);

// *** sdram_pin_defs.vh ***
`ifndef SDRAM_PIN_DEFS_VH
`define SDRAM_PIN_DEFS_VH
`define CMD_MRS 3'h0
`define CMD_REF 3'h1
`define CMD_PRE 3'h2
`define CMD_ACT 3'h3
`define CMD_WR 3'h4
`define CMD_ZQ 3'h6
`define CMD_RD 3'h5
`define CMD_NOP 3'h7
`define MR_SEL_TERM_A 3'h1
`define MR_SEL_SR 3'h2
`define SR_ASR_BIT 6
`define SR_EXT_BIT 7
`define AP_BIT 10
`define BC_BIT 12
`define ST_IDLE 2'h0
`define ST_ACTIVE 2'h1
`define ST_PDOWN 2'h2
`define ST_SREF 2'h3
`endif
